/* design/pin_sync.v */
/*
 * Three-stage synchroniser for a group of asynchronous pin levels.
 * Assumes its inputs come from outside the mclk domain; the output
 * only moves once the second and third stages agree.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
   parameter WIDTH = 1
) (
   input wire mclk, // system clock
   input wire rst, // async reset, active high
   input wire [WIDTH-1:0] pin_in, // raw pin levels
   input wire [WIDTH-1:0] rst_val, // idle level for the caller; reset loads zeros
   output reg [WIDTH-1:0] level_q // filtered, synchronous levels
);

   reg [WIDTH-1:0] s1_q;
   reg [WIDTH-1:0] s2_q;
   reg [WIDTH-1:0] s3_q;
   integer i;

   // stage one is read only by stage two
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_q <= {WIDTH{1'b0}};
         s2_q <= {WIDTH{1'b0}};
         s3_q <= {WIDTH{1'b0}};
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // level follows only on agreement, which hides one-stage upsets
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         level_q <= {WIDTH{1'b0}};
      end else begin
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
               level_q[i] <= s3_q[i];
            end
         end
      end
   end

   // rst_val only names the safe idle state for the caller
   wire unused_rst_val = |rst_val;

endmodule

`default_nettype wire

/* design/wdt_map.vh */
/*
 * Constants for the window watchdog and wake-up control: mode and
 * watchdog state codes, window lengths in oscillator periods and
 * wake and trigger filter times.
 * Assumes the including module runs on a 25 MHz mclk.
 */
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// mclk period
`define CLK_PER_NS 40

// operating modes
`define MODE_PRE 2'h0
`define MODE_NORMAL 2'h1
`define MODE_SILENT 2'h2
`define MODE_SLEEP 2'h3

// watchdog sequence states
`define WD_OFF 3'h0
`define WD_POR 3'h1
`define WD_LEAD 3'h2
`define WD_CLOSED 3'h3
`define WD_OPEN 3'h4
`define WD_RST 3'h5

// watchdog intervals in oscillator periods
`define LEAD_PER 12'hF52
`define CLOSED_PER 12'h320
`define OPEN_PER 12'h348
`define NRES_PER 12'h09D

// trigger pulse must last longer than this
`define TRIG_MIN_NS 3000
`define TRIG_CYC (`TRIG_MIN_NS / `CLK_PER_NS + 1)

// wake filter times, in microseconds
`define BUS_WAKE_US 100
`define BUS_WAKE_CYC ((`BUS_WAKE_US * 1000) / `CLK_PER_NS)
`define LOCAL_WAKE_US 50
`define LOCAL_WAKE_CYC ((`LOCAL_WAKE_US * 1000) / `CLK_PER_NS)

// long times, in microseconds; their counts are top parameters
`define POR_US 10000
`define SHORT_US 4000
`define OPEN_US 7000

`endif

/* design/window_watchdog_wake_control.v */
/*
 * Window watchdog, mode control and wake-up logic of a LIN system
 * basis chip. Oscillator periods arrive as a square wave from the
 * resistor-set oscillator; all pins are asynchronous to mclk.
 * Assumes the host drives mode select, transmit and both triggers.
 */
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.vh"

// Behaviour
// - bus wake from sleep/silent enters pre-normal
// - remote wake: receive low, transmit driven high
// - local switch low held wakes to pre-normal
// - local wake: receive low, transmit driven low
// - mode select high clears both wake flags
// - mid-level bus counts as local wake
// - missing valid trigger asserts reset output
// - triggers of 3 us or less are ignored
// - watchdog off in silent and sleep
// - lead time 3922 periods after reset release
// - closed 800, open 840 oscillator periods
// - no trigger in lead: 157-period reset
// - trigger in lead starts closed window
// - trigger in open window restarts closed window
// - open window expiry pulls reset low
// - trigger in closed window resets at once
// - every reset restarts with lead time
// - power-up or sleep wake holds reset 10 ms
// - silent wake starts lead with receive low
// - resistor short 4 ms, open 7 ms reset
// - undervoltage resets, forces pre-normal, regulator on
// - debug strap high disables the watchdog
// - pre-normal until mode select goes high
// - select falling with transmit high gives silent
// - select falling with transmit low gives sleep
module window_watchdog_wake_control #(
   parameter POR_CYC = (`POR_US * 1000) / `CLK_PER_NS,
   parameter SHORT_CYC = (`SHORT_US * 1000) / `CLK_PER_NS,
   parameter OPEN_CYC = (`OPEN_US * 1000) / `CLK_PER_NS
) (
   input wire mclk, // system clock, 25 MHz
   input wire rst, // supply reset, async, active high
   input wire mode_select_in, // host mode select pin
   input wire transmit_input, // transmit pin, host side level
   input wire trigger_fall_in, // falling-edge trigger pin
   input wire trigger_rise_in, // rising-edge trigger pin
   input wire bus_dominant_in, // bus comparator, high = dominant
   input wire bus_mid_in, // bus between 0.6 supply and supply-3.3V
   input wire local_switch_in, // local wake pin, low = active
   input wire osc_clk_in, // watchdog oscillator square wave
   input wire debug_strap_in, // high switches watchdog off
   input wire res_short_in, // timing_resistor_pin shorted to ground
   input wire res_open_in, // timing_resistor_pin left open
   input wire undervolt_in, // regulator undervoltage detector
   output reg receive_output, // receive pin level
   output reg transmit_out, // wake source on transmit pin
   output reg transmit_oe, // high while device drives transmit pin
   output reg reset_out_n, // reset to host, active low
   output reg regulator_on, // regulator enable
   output reg termination_on, // slave termination enable
   output reg transceiver_on, // transmit path enable
   output reg osc_enable, // watchdog oscillator enable
   output reg [1:0] mode_q // current operating mode
);

   localparam [15:0] TRIG_CYC = `TRIG_CYC;
   localparam [15:0] BUS_CYC = `BUS_WAKE_CYC;
   localparam [15:0] LOC_CYC = `LOCAL_WAKE_CYC;
   localparam [17:0] POR_LAST = POR_CYC - 1;
   localparam [17:0] SHORT_LAST = SHORT_CYC - 1;
   localparam [17:0] OPEN_LAST = OPEN_CYC - 1;

   // saturating hold timer: starts at an edge, runs while level holds
   function [15:0] held;
      input [15:0] cnt;
      input start;
      input level;
      begin
         if (start) begin
            held = 16'h0001;
         end else if (cnt != 16'h0000 && level) begin
            held = (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
         end else begin
            held = 16'h0000;
         end
      end
   endfunction

   // fault timer: counts while the fault stands, wraps to repeat
   function [17:0] fault_next;
      input [17:0] cnt;
      input level;
      input [17:0] last;
      begin
         if (!level || cnt == last) begin
            fault_next = 18'h00000;
         end else begin
            fault_next = cnt + 18'h00001;
         end
      end
   endfunction

   wire [11:0] sync_q;
   wire en_s = sync_q[0];
   wire txd_s = sync_q[1];
   wire tfall_s = sync_q[2];
   wire trise_s = sync_q[3];
   wire dom_s = sync_q[4];
   wire mid_s = sync_q[5];
   wire wake_s = sync_q[6];
   wire osc_s = sync_q[7];
   wire dbg_s = sync_q[8];
   wire short_s = sync_q[9];
   wire open_s = sync_q[10];
   wire uv_s = sync_q[11];

   pin_sync #(
      .WIDTH(12)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .pin_in({undervolt_in, res_open_in, res_short_in, debug_strap_in,
               osc_clk_in, local_switch_in, bus_mid_in, bus_dominant_in,
               trigger_rise_in, trigger_fall_in, transmit_input,
               mode_select_in}),
      .rst_val(12'h000),
      .level_q(sync_q)
   );

   reg [11:0] prev_q;
   reg [15:0] bus_cnt_q, loc_cnt_q, mid_cnt_q, fall_cnt_q, rise_cnt_q;
   reg [17:0] por_cnt_q, short_cnt_q, open_cnt_q;
   reg [11:0] osc_cnt_q;
   reg [2:0] wd_q;
   reg [2:0] wd_d;
   reg [1:0] mode_d;
   reg wake_req_q, wake_src_q;

   // edges of the synchronised levels
   wire en_fall = prev_q[0] & ~en_s;
   wire tfall_edge = prev_q[2] & ~tfall_s;
   wire trise_edge = ~prev_q[3] & trise_s;
   wire dom_edge = ~prev_q[4] & dom_s;
   wire mid_edge = ~prev_q[5] & mid_s;
   wire wake_edge = prev_q[6] & ~wake_s;
   wire osc_tick = ~prev_q[7] & osc_s;

   wire asleep = (mode_q == `MODE_SLEEP) || (mode_q == `MODE_SILENT);
   wire remote_wake = asleep && (bus_cnt_q == BUS_CYC);
   wire local_wake = asleep && ((loc_cnt_q == LOC_CYC) ||
                                (mid_cnt_q == LOC_CYC));
   wire any_wake = remote_wake | local_wake;
   // only a pulse that outlasts the glitch filter counts
   wire trig = (fall_cnt_q == TRIG_CYC) || (rise_cnt_q == TRIG_CYC);
   wire fault = (short_cnt_q == SHORT_LAST) ||
                (open_cnt_q == OPEN_LAST);
   wire uv_hit = uv_s && (mode_q != `MODE_SLEEP);
   wire wd_en = ~dbg_s && !asleep;

   // edge history and filter timers
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         prev_q <= 12'h000;
         bus_cnt_q <= 16'h0000;
         loc_cnt_q <= 16'h0000;
         mid_cnt_q <= 16'h0000;
         fall_cnt_q <= 16'h0000;
         rise_cnt_q <= 16'h0000;
         short_cnt_q <= 18'h00000;
         open_cnt_q <= 18'h00000;
      end else begin
         prev_q <= sync_q;
         bus_cnt_q <= held(bus_cnt_q, dom_edge, dom_s);
         loc_cnt_q <= held(loc_cnt_q, wake_edge, ~wake_s);
         mid_cnt_q <= held(mid_cnt_q, mid_edge, mid_s);
         fall_cnt_q <= held(fall_cnt_q, tfall_edge, ~tfall_s);
         rise_cnt_q <= held(rise_cnt_q, trise_edge, trise_s);
         short_cnt_q <= fault_next(short_cnt_q, short_s, SHORT_LAST);
         open_cnt_q <= fault_next(open_cnt_q, open_s, OPEN_LAST);
      end
   end

   // mode selection; no change while the power-on reset runs
   always @* begin
      mode_d = mode_q;
      case (mode_q)
         `MODE_PRE: begin
            if (en_s && wd_q != `WD_POR) begin
               mode_d = `MODE_NORMAL;
            end
         end
         `MODE_NORMAL: begin
            if (uv_hit) begin
               mode_d = `MODE_PRE;
            end else if (en_fall) begin
               mode_d = txd_s ? `MODE_SILENT : `MODE_SLEEP;
            end
         end
         `MODE_SILENT: begin
            if (uv_hit || any_wake) begin
               mode_d = `MODE_PRE;
            end else if (en_s) begin
               mode_d = `MODE_NORMAL;
            end
         end
         `MODE_SLEEP: begin
            if (any_wake) begin
               mode_d = `MODE_PRE;
            end
         end
         default: begin
            mode_d = `MODE_PRE;
         end
      endcase
   end

   // watchdog sequence; window counts advance on oscillator periods, the power-on count on mclk cycles
   always @* begin
      wd_d = wd_q;
      if ((mode_q == `MODE_SLEEP && any_wake) || uv_hit) begin
         wd_d = `WD_POR;
      end else if (fault) begin
         wd_d = `WD_RST;
      end else begin
         case (wd_q)
            `WD_OFF: begin
               if (wd_en) begin
                  wd_d = `WD_LEAD;
               end
            end
            `WD_POR: begin
               if (por_cnt_q == POR_LAST) begin
                  wd_d = wd_en ? `WD_LEAD : `WD_OFF;
               end
            end
            `WD_LEAD: begin
               if (!wd_en) begin
                  wd_d = `WD_OFF;
               end else if (trig) begin
                  wd_d = `WD_CLOSED;
               end else if (osc_tick && osc_cnt_q == `LEAD_PER - 1) begin
                  wd_d = `WD_RST;
               end
            end
            `WD_CLOSED: begin
               if (!wd_en) begin
                  wd_d = `WD_OFF;
               end else if (trig) begin
                  wd_d = `WD_RST;
               end else if (osc_tick && osc_cnt_q == `CLOSED_PER - 1) begin
                  wd_d = `WD_OPEN;
               end
            end
            `WD_OPEN: begin
               if (!wd_en) begin
                  wd_d = `WD_OFF;
               end else if (trig) begin
                  wd_d = `WD_CLOSED;
               end else if (osc_tick && osc_cnt_q == `OPEN_PER - 1) begin
                  wd_d = `WD_RST;
               end
            end
            `WD_RST: begin
               if (osc_tick && osc_cnt_q == `NRES_PER - 1) begin
                  wd_d = wd_en ? `WD_LEAD : `WD_OFF;
               end
            end
            default: begin
               wd_d = `WD_OFF;
            end
         endcase
      end
   end

   // state registers and interval counters
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_q <= `MODE_PRE;
         wd_q <= `WD_POR;
         osc_cnt_q <= 12'h000;
         por_cnt_q <= 18'h00000;
      end else begin
         mode_q <= mode_d;
         wd_q <= wd_d;
         if (wd_d != wd_q || uv_hit) begin
            osc_cnt_q <= 12'h000;
            por_cnt_q <= 18'h00000;
         end else begin
            if (osc_tick) begin
               osc_cnt_q <= osc_cnt_q + 12'h001;
            end
            por_cnt_q <= por_cnt_q + 18'h00001;
         end
      end
   end

   // wake flags; a new wake wins over a clear in the same cycle
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wake_req_q <= 1'b0;
         wake_src_q <= 1'b0;
      end else if (any_wake) begin
         wake_req_q <= 1'b1;
         wake_src_q <= remote_wake;
      end else if (en_s) begin
         wake_req_q <= 1'b0;
         wake_src_q <= 1'b0;
      end
   end

   // pin and enable outputs, all registered from next-state values
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         receive_output <= 1'b1;
         transmit_out <= 1'b0;
         transmit_oe <= 1'b0;
         reset_out_n <= 1'b0;
         regulator_on <= 1'b1;
         termination_on <= 1'b1;
         transceiver_on <= 1'b0;
         osc_enable <= 1'b1;
      end else begin
         if (mode_d == `MODE_NORMAL) begin
            receive_output <= ~dom_s;
         end else if (mode_d == `MODE_SLEEP || any_wake) begin
            receive_output <= 1'b0;
         end else begin
            receive_output <= ~wake_req_q;
         end
         // source is shown only while pre-normal holds a request
         transmit_out <= any_wake ? remote_wake : wake_src_q;
         transmit_oe <= (mode_d == `MODE_PRE) &&
                        (any_wake || (wake_req_q && !en_s));
         reset_out_n <= !(wd_d == `WD_POR || wd_d == `WD_RST ||
                          mode_d == `MODE_SLEEP);
         regulator_on <= (mode_d != `MODE_SLEEP);
         termination_on <= (mode_d == `MODE_PRE) ||
                           (mode_d == `MODE_NORMAL);
         transceiver_on <= (mode_d == `MODE_NORMAL);
         osc_enable <= (mode_d == `MODE_PRE) ||
                       (mode_d == `MODE_NORMAL);
      end
   end

endmodule

`default_nettype wire

/* tb/host_mcu.sv */
/*
 * Host microcontroller model: mode select, transmit level, triggers.
 * Assumes the bench's mclk; pins move 1 ns after a rising edge.
 */
`timescale 1ns/1ns
`default_nettype none

module host_mcu (
   input wire logic mclk, // system clock
   output logic mode_select_in, // mode select pin
   output logic host_tx, // transmit level while device releases it
   output logic trigger_fall_in, // falling-edge trigger
   output logic trigger_rise_in // rising-edge trigger
);
   // idle: triggers inactive, transmit recessive
   initial begin
      mode_select_in = 1'h0;
      host_tx = 1'h1;
      trigger_fall_in = 1'h1;
      trigger_rise_in = 1'h0;
   end

   // pulse of w cycles; short ones only when the bench asks
   task trig(input logic fall, input integer w);
      begin
         @(posedge mclk);
         #1;
         if (fall)
            trigger_fall_in = 1'h0;
         else
            trigger_rise_in = 1'h1;
         repeat (w) @(posedge mclk);
         #1;
         trigger_fall_in = 1'h1;
         trigger_rise_in = 1'h0;
      end
   endtask

   // transmit settles before the select edge and holds well after
   task sel(input logic s, input logic t);
      begin
         @(posedge mclk);
         #1;
         host_tx = t;
         repeat (6) @(posedge mclk);
         #1;
         mode_select_in = s;
         repeat (8) @(posedge mclk);
         #1;
      end
   endtask
endmodule
`default_nettype wire

/* tb/window_watchdog_wake_control_test.sv */
/*
 * Self-checking bench for the window watchdog and wake control block.
 * Assumes shortened power-on and fault counts; oscillator = 4 mclk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.vh"

module window_watchdog_wake_control_test;
   logic mclk, rst, bus_dominant_in, bus_mid_in, local_switch_in;
   logic osc_clk_in, debug_strap_in, res_short_in, res_open_in;
   logic undervolt_in;
   wire receive_output, transmit_out, transmit_oe, reset_out_n;
   wire regulator_on, termination_on, transceiver_on, osc_enable;
   wire host_tx, mode_select_in, trigger_fall_in, trigger_rise_in;
   wire [1:0] mode_q;
   integer error_cnt, n_compared;

   // pin level: device drives it while enabled, else the host
   wire transmit_input = transmit_oe ? transmit_out : host_tx;

   always #20 mclk = ~mclk;
   // each osc level lasts two mclk so the agreeing pin filter follows it
   always #80 osc_clk_in = ~osc_clk_in;

   // power-on long enough that its low phase spans 157 osc periods too
   window_watchdog_wake_control #(.POR_CYC(700), .SHORT_CYC(100),
      .OPEN_CYC(150)) dut (.mclk, .rst, .mode_select_in, .transmit_input,
      .trigger_fall_in, .trigger_rise_in, .bus_dominant_in, .bus_mid_in,
      .local_switch_in, .osc_clk_in, .debug_strap_in, .res_short_in,
      .res_open_in, .undervolt_in, .receive_output, .transmit_out,
      .transmit_oe, .reset_out_n, .regulator_on, .termination_on,
      .transceiver_on, .osc_enable, .mode_q);

   host_mcu host (.mclk, .mode_select_in, .host_tx, .trigger_fall_in,
      .trigger_rise_in);

   task tick(input integer n);
      begin
         repeat (n) @(posedge mclk);
         #1;
      end
   endtask

   task check(input logic seen, input logic exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
         end
      end
   endtask

   // bounded wait for the reset level; the span must fall in [lo, hi]
   task edge_in(input logic lvl, input integer lo, input integer hi);
      integer n;
      begin
         n = 0;
         while (reset_out_n !== lvl && n <= hi) begin
            tick(1);
            n = n + 1;
         end
         check(n >= lo && n <= hi, 1'h1);
      end
   endtask

   task final_report;
      begin
         $display("compared %0d, wrong %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   task t_power_up;
      begin
         edge_in(1'h1, 695, 712);
         edge_in(1'h0, 15675, 15700);
         edge_in(1'h1, 620, 635);
      end
   endtask

   // second trigger lands in the open window, then none
   task t_windows;
      begin
         host.trig(1'h0, 100);
         tick(3400);
         host.trig(1'h1, 100);
         edge_in(1'h0, 6525, 6560);
         edge_in(1'h1, 620, 635);
      end
   endtask

   // a glitch, then a real trigger, inside the closed window
   task t_closed;
      begin
         host.trig(1'h0, 100);
         host.trig(1'h1, 40);
         tick(60);
         check(reset_out_n, 1'h1);
         host.trig(1'h0, 100);
         check(reset_out_n, 1'h0);
         edge_in(1'h1, 595, 625);
      end
   endtask

   task t_modes;
      begin
         host.sel(1'h1, 1'h1);
         check(transceiver_on, 1'h1);
         host.sel(1'h0, 1'h1);
         check(mode_q === `MODE_SILENT, 1'h1);
         check(osc_enable, 1'h0);
         tick(16000);
         check(reset_out_n, 1'h1);
         bus_dominant_in = 1'h1;
         tick(2600);
         check(termination_on && mode_q === `MODE_PRE, 1'h1);
         check(receive_output, 1'h0);
         check(transmit_out && transmit_oe, 1'h1);
         bus_dominant_in = 1'h0;
         host.sel(1'h1, 1'h1);
         check(transmit_oe, 1'h0);
         host.sel(1'h0, 1'h0);
         check(mode_q === `MODE_SLEEP, 1'h1);
         local_switch_in = 1'h0;
         tick(1350);
         check(termination_on && mode_q === `MODE_PRE, 1'h1);
         check(receive_output || transmit_out, 1'h0);
         check(transmit_oe, 1'h1);
         local_switch_in = 1'h1;
         edge_in(1'h1, 550, 650);
         host.sel(1'h1, 1'h1);
         host.sel(1'h0, 1'h1);
         bus_mid_in = 1'h1;
         tick(1350);
         check(receive_output || transmit_input, 1'h0);
         bus_mid_in = 1'h0;
      end
   endtask

   task t_faults;
      begin
         res_short_in = 1'h1;
         edge_in(1'h0, 95, 130);
         res_short_in = 1'h0;
         edge_in(1'h1, 615, 640);
         res_open_in = 1'h1;
         edge_in(1'h0, 145, 180);
         res_open_in = 1'h0;
         edge_in(1'h1, 615, 640);
         host.sel(1'h1, 1'h1);
         host.sel(1'h0, 1'h1);
         undervolt_in = 1'h1;
         tick(10);
         check(reset_out_n, 1'h0);
         check(regulator_on && mode_q === `MODE_PRE, 1'h1);
         undervolt_in = 1'h0;
         edge_in(1'h1, 695, 715);
      end
   endtask

   // lead would expire inside this wait if the strap were ignored
   task t_strap;
      begin
         host.sel(1'h1, 1'h1);
         debug_strap_in = 1'h1;
         tick(16000);
         check(reset_out_n, 1'h1);
         debug_strap_in = 1'h0;
      end
   endtask

   // hang guard, well past the expected run length
   initial begin
      #3600000;
      error_cnt = error_cnt + 1;
      final_report;
   end

   initial begin
      mclk = 1'h0;
      osc_clk_in = 1'h0;
      rst = 1'h1;
      bus_dominant_in = 1'h0;
      bus_mid_in = 1'h0;
      local_switch_in = 1'h1;
      debug_strap_in = 1'h0;
      res_short_in = 1'h0;
      res_open_in = 1'h0;
      undervolt_in = 1'h0;
      error_cnt = 0;
      n_compared = 0;
      tick(8);
      rst = 1'h0;
      t_power_up;
      t_windows;
      t_closed;
      t_modes;
      t_faults;
      t_strap;
      final_report;
   end
endmodule
`default_nettype wire

/* tb/wwd_monitor.sv */
/*
 * Assertion checker for the window watchdog and wake control block.
 * Assumes it is bound to that block and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
`include "wdt_map.vh"

module wwd_monitor (
   input wire logic mclk, // clock
   input wire logic rst, // reset
   input wire logic mode_select_in, // mode select
   input wire logic osc_clk_in, // oscillator
   input wire logic debug_strap_in, // strap
   input wire logic res_short_in, // resistor short
   input wire logic res_open_in, // resistor open
   input wire logic undervolt_in, // undervoltage
   input wire logic receive_output, // receive pin
   input wire logic transmit_oe, // transmit drive
   input wire logic reset_out_n, // host reset
   input wire logic regulator_on, // regulator
   input wire logic termination_on, // termination
   input wire logic transceiver_on, // transmit path
   input wire logic [1:0] mode_q // mode
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (rst);

   // osc edges while reset is low; saturates so long holds never wrap
   logic osc_q;
   logic [8:0] low_cnt_q;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         osc_q <= 1'h0;
         low_cnt_q <= 9'h000;
      end else begin
         osc_q <= osc_clk_in;
         if (reset_out_n)
            low_cnt_q <= 9'h000;
         else if (osc_clk_in && !osc_q && low_cnt_q != 9'h1FF)
            low_cnt_q <= low_cnt_q + 9'h001;
      end
   end

   property p_por_hold;
      $fell(rst) |-> !reset_out_n [*8];
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("early release");
   property p_sleep_off;
      mode_q == `MODE_SLEEP |-> !regulator_on && !receive_output;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("sleep outputs");
   property p_silent;
      mode_q == `MODE_SILENT |-> regulator_on && !transceiver_on;
   endproperty
   a_silent: assert property (p_silent) else $error("silent outputs");
   property p_prenormal;
      mode_q == `MODE_PRE |-> regulator_on && termination_on
         && !transceiver_on;
   endproperty
   a_prenormal: assert property (p_prenormal) else $error("pre outputs");
   property p_wake_flag;
      transmit_oe |-> mode_q == `MODE_PRE && !receive_output;
   endproperty
   a_wake_flag: assert property (p_wake_flag) else $error("wake flag");
   property p_sel_clear;
      mode_select_in [*8] |-> !transmit_oe;
   endproperty
   a_sel_clear: assert property (p_sel_clear) else $error("flag kept");
   property p_rst_width;
      $rose(reset_out_n) |-> low_cnt_q >= 9'h09A;
   endproperty
   a_rst_width: assert property (p_rst_width) else $error("short reset");
   property p_strap_off;
      (debug_strap_in && !res_short_in && !res_open_in && !undervolt_in
         && reset_out_n && mode_q == `MODE_NORMAL) [*8]
         |=> reset_out_n || mode_q == `MODE_SLEEP;
   endproperty
   a_strap_off: assert property (p_strap_off) else $error("strap reset");
endmodule

bind window_watchdog_wake_control wwd_monitor mon (.mclk, .rst,
   .mode_select_in, .osc_clk_in, .debug_strap_in, .res_short_in,
   .res_open_in, .undervolt_in, .receive_output, .transmit_oe,
   .reset_out_n, .regulator_on, .termination_on, .transceiver_on,
   .mode_q);
`default_nettype wire
